/* inc/rtc_i2c_pkg.sv */
// constants and types shared by both ends of the rtc serial link
// assumes a 20 MHz master clock; the slave runs on its own link clock
package rtc_i2c_pkg;

   // ==========================================
   // framing
   localparam int BYTE_BITS = 8;
   localparam logic [3:0] BYTE_CNT = 4'h8;
   localparam logic [3:0] RECOVER_LAST = 4'h8;
   localparam logic [6:0] SLAVE_ADDR = 7'h51;
   localparam int PTR_W = 5;

   // ==========================================
   // timing
   localparam int MCLK_NS = 50;
   localparam int SCL_PERIOD_NS = 2500;
   // least quarter period, rounded up to whole cycles
   localparam int QTR_CYC = (SCL_PERIOD_NS / 4 + MCLK_NS - 1) / MCLK_NS;
   localparam int QTR_W = 5;
   localparam logic [QTR_W-1:0] QTR_LAST = QTR_W'(QTR_CYC - 1);

   // ==========================================
   // types
   typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} dev_state_t;
   typedef enum logic [1:0] {PH_ADDR, PH_PTR, PH_DATA} byte_kind_t;
   typedef enum logic [1:0] {M_IDLE, M_START, M_BITS, M_STOP} mst_state_t;
   typedef enum logic [2:0] {CMD_START, CMD_STOP, CMD_WRITE, CMD_READ, CMD_RECOVER} mst_cmd_t;

endpackage

/* inc/i2c_link_if.sv */
// two-wire open-drain link between bus master and rtc slave
// wired-and of the drivers; both lines read high when released
`timescale 1ns/1ps
`default_nettype none
interface i2c_link_if;
   logic scl_m_out;
   logic scl_m_oe;
   logic sda_m_out;
   logic sda_m_oe;
   logic sda_d_out;
   logic sda_d_oe;
   logic scl;
   logic sda;

   // ==========================================
   // line resolution
   assign scl = ~(scl_m_oe & ~scl_m_out);
   assign sda = ~((sda_m_oe & ~sda_m_out) | (sda_d_oe & ~sda_d_out));

   modport mst(output scl_m_out, scl_m_oe, sda_m_out, sda_m_oe, input sda);
   modport dev(output sda_d_out, sda_d_oe, input scl, sda);
endinterface
`default_nettype wire

/* rtl/pin_sync.sv */
// three-stage pin synchroniser with agreement filter
// pin is asynchronous to clk_in
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // pin
   input wire logic pin_in,
   output logic level_out
);
   logic meta;
   logic s2;
   logic s3;

   // ==========================================
   // stages
   always_ff @(posedge clk_in) begin
      meta <= pin_in;
      s2 <= meta;
      s3 <= s2;
   end

   // released lines rest high, so reset to high
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         level_out <= 1'b1;
      end else if (s2 == s3) begin
         level_out <= s3;
      end
   end
endmodule
`default_nettype wire

/* rtl/i2c_rtc_slave.sv */
// rtc slave end of the two-wire link: framing, address match, pointer
// runs wholly on link_clk_in; rst_in is synchronous to that clock
// Operation
// - byte is eight bits plus acknowledge
// - unlimited data bytes per transfer
// - acknowledge every received byte when addressed
// - master acknowledges read bytes except last
// - acknowledger holds data low through clock high
// - no master acknowledge releases data line
// - respond only to address 1010001
// - address bit zero selects write or read
// - address byte follows start immediately
// - stop or start ends write transfer
// - pointer uses low five bits only
// - nine clocks return machine to idle; code does so only in a read, a write stays in ST_RX/ST_ACK
// - extra recovery clocks leave device idle
// - master software offers bus recovery
// - start is data fall, clock high
// - stop is data rise, clock high
// - data stable while clock high
`timescale 1ns/1ps
`default_nettype none
module i2c_rtc_slave
   import rtc_i2c_pkg::*;
(
   // clock and reset
   input wire logic link_clk_in,
   input wire logic rst_in,
   // link
   i2c_link_if.dev link,
   // register write side
   output logic wr_valid_out,
   output logic [PTR_W-1:0] wr_addr_out,
   output logic [7:0] wr_data_out,
   // register read side
   output logic [PTR_W-1:0] rd_addr_out,
   input wire logic [7:0] rd_data_in,
   output logic rd_take_out,
   // status
   output logic busy_out,
   output logic sel_out
);
   dev_state_t state;
   byte_kind_t kind;
   logic scl_s;
   logic sda_s;
   logic scl_d;
   logic sda_d;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   logic [3:0] cnt;
   logic [7:0] shreg;
   logic rd_dir;
   logic mack;
   logic sda_drv;
   logic byte_done;
   logic load_tx;
   logic [PTR_W-1:0] ptr;

   // ==========================================
   // pin sampling
   pin_sync u_scl (
      .clk_in(link_clk_in),
      .rst_in(rst_in),
      .pin_in(link.scl),
      .level_out(scl_s)
   );

   pin_sync u_sda (
      .clk_in(link_clk_in),
      .rst_in(rst_in),
      .pin_in(link.sda),
      .level_out(sda_s)
   );

   always_ff @(posedge link_clk_in) begin
      if (rst_in) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   // ==========================================
   // bus conditions
   assign scl_rise = scl_s & ~scl_d;
   assign scl_fall = ~scl_s & scl_d;
   // start and stop need clock high in both samples, so data changes in low phase are harmless
   assign start_c = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_c = scl_s & scl_d & ~sda_d & sda_s;
   assign byte_done = (state == ST_RX) && scl_fall && (cnt == BYTE_CNT);
   assign load_tx = scl_fall && (((state == ST_ACK) && rd_dir) || ((state == ST_MACK) && mack));

   // ==========================================
   // bit and byte machine
   always_ff @(posedge link_clk_in) begin
      if (rst_in) begin
         state <= ST_IDLE;
         cnt <= 4'h0;
         shreg <= 8'h00;
         sda_drv <= 1'b0;
      end else if (start_c) begin
         // repeated start also lands here, ending any write
         state <= ST_RX;
         cnt <= 4'h0;
         sda_drv <= 1'b0;
      end else if (stop_c) begin
         state <= ST_IDLE;
         sda_drv <= 1'b0;
      end else begin
         case (state)
            ST_RX: begin
               if (scl_rise) begin
                  shreg <= {shreg[6:0], sda_s};
                  cnt <= cnt + 4'h1;
               end else if (byte_done) begin
                  cnt <= 4'h0;
                  if ((kind == PH_ADDR) && (shreg[7:1] != SLAVE_ADDR)) begin
                     state <= ST_IDLE;
                  end else begin
                     state <= ST_ACK;
                     sda_drv <= 1'b1;
                  end
               end
            end
            ST_ACK: begin
               if (load_tx) begin
                  state <= ST_TX;
                  shreg <= rd_data_in;
                  sda_drv <= ~rd_data_in[7];
                  cnt <= 4'h1;
               end else if (scl_fall) begin
                  state <= ST_RX;
                  sda_drv <= 1'b0;
                  cnt <= 4'h0;
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (cnt == BYTE_CNT) begin
                     state <= ST_MACK;
                     sda_drv <= 1'b0;
                  end else begin
                     shreg <= {shreg[6:0], 1'b1};
                     sda_drv <= ~shreg[6];
                     cnt <= cnt + 4'h1;
                  end
               end
            end
            ST_MACK: begin
               if (load_tx) begin
                  state <= ST_TX;
                  shreg <= rd_data_in;
                  sda_drv <= ~rd_data_in[7];
                  cnt <= 4'h1;
               end else if (scl_fall) begin
                  // line already released; further clocks find us idle
                  state <= ST_IDLE;
                  sda_drv <= 1'b0;
               end
            end
            default: begin
               state <= ST_IDLE;
               sda_drv <= 1'b0;
            end
         endcase
      end
   end

   // master acknowledge, taken on the ninth rising clock
   always_ff @(posedge link_clk_in) begin
      if (rst_in) begin
         mack <= 1'b0;
      end else if ((state == ST_MACK) && scl_rise) begin
         mack <= ~sda_s;
      end
   end

   // ==========================================
   // transfer phase and direction
   always_ff @(posedge link_clk_in) begin
      if (rst_in) begin
         kind <= PH_ADDR;
         rd_dir <= 1'b0;
      end else if (start_c) begin
         kind <= PH_ADDR;
         rd_dir <= 1'b0;
      end else if (byte_done) begin
         case (kind)
            PH_ADDR: begin
               rd_dir <= shreg[0];
               kind <= shreg[0] ? PH_DATA : PH_PTR;
            end
            PH_PTR: kind <= PH_DATA;
            default: kind <= PH_DATA;
         endcase
      end
   end

   // ==========================================
   // register pointer
   always_ff @(posedge link_clk_in) begin
      if (rst_in) begin
         ptr <= '0;
      end else if (byte_done && (kind == PH_PTR)) begin
         ptr <= shreg[PTR_W-1:0];
      end else if (byte_done && (kind == PH_DATA) && !rd_dir) begin
         ptr <= ptr + PTR_W'(1);
      end else if (load_tx) begin
         ptr <= ptr + PTR_W'(1);
      end
   end

   // ==========================================
   // user side
   always_ff @(posedge link_clk_in) begin
      if (rst_in) begin
         wr_valid_out <= 1'b0;
         wr_addr_out <= '0;
         wr_data_out <= 8'h00;
         rd_take_out <= 1'b0;
      end else begin
         wr_valid_out <= byte_done && (kind == PH_DATA) && !rd_dir;
         if (byte_done) begin
            wr_addr_out <= ptr;
            wr_data_out <= shreg;
         end
         rd_take_out <= load_tx;
      end
   end

   // read data must be valid for rd_addr_out; it follows the pointer
   assign rd_addr_out = ptr;

   always_ff @(posedge link_clk_in) begin
      if (rst_in) begin
         busy_out <= 1'b0;
         sel_out <= 1'b0;
      end else begin
         busy_out <= (state != ST_IDLE);
         if (start_c || stop_c) begin
            sel_out <= 1'b0;
         end else if (byte_done && (kind == PH_ADDR)) begin
            sel_out <= (shreg[7:1] == SLAVE_ADDR);
         end
      end
   end

   // ==========================================
   // open-drain data driver
   assign link.sda_d_oe = sda_drv;
   assign link.sda_d_out = 1'b0;
endmodule
`default_nettype wire

/* rtl/i2c_rtc_master.sv */
// bus master end: start, stop, byte write, byte read, nine-clock recovery
// makes the link clock by dividing mclk_in; sda comes back asynchronously
`timescale 1ns/1ps
`default_nettype none
module i2c_rtc_master
   import rtc_i2c_pkg::*;
(
   // clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // link
   i2c_link_if.mst link,
   // command
   input wire logic cmd_valid_in,
   input wire mst_cmd_t cmd_kind_in,
   input wire logic [7:0] cmd_data_in,
   input wire logic cmd_ack_in,
   output logic cmd_ready_out,
   // answer
   output logic done_out,
   output logic [7:0] rd_data_out,
   output logic ack_out
);
   mst_state_t state;
   logic [QTR_W-1:0] qcnt;
   logic [1:0] ph;
   logic tick;
   logic sda_s;
   logic scl_low;
   logic sda_low;
   logic [8:0] txv;
   logic [8:0] rxv;
   logic [3:0] nbit;
   logic then_stop;

   pin_sync u_sda (
      .clk_in(mclk_in),
      .rst_in(rst_in),
      .pin_in(link.sda),
      .level_out(sda_s)
   );

   // ==========================================
   // quarter-bit divider
   assign tick = (qcnt == QTR_LAST);

   always_ff @(posedge mclk_in) begin
      if (rst_in || (state == M_IDLE)) begin
         qcnt <= '0;
         ph <= 2'h0;
      end else if (tick) begin
         qcnt <= '0;
         ph <= ph + 2'h1;
      end else begin
         qcnt <= qcnt + QTR_W'(1);
      end
   end

   // ==========================================
   // sequencer
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         state <= M_IDLE;
         scl_low <= 1'b0;
         sda_low <= 1'b0;
         cmd_ready_out <= 1'b1;
         done_out <= 1'b0;
         txv <= 9'h1ff;
         rxv <= 9'h000;
         nbit <= 4'h0;
         then_stop <= 1'b0;
         rd_data_out <= 8'h00;
         ack_out <= 1'b0;
      end else begin
         done_out <= 1'b0;
         case (state)
            M_IDLE: begin
               if (cmd_valid_in && cmd_ready_out) begin
                  cmd_ready_out <= 1'b0;
                  nbit <= 4'h0;
                  then_stop <= 1'b0;
                  case (cmd_kind_in)
                     CMD_START: state <= M_START;
                     CMD_STOP: state <= M_STOP;
                     CMD_WRITE: begin
                        txv <= {cmd_data_in, 1'b1};
                        state <= M_BITS;
                     end
                     CMD_READ: begin
                        // last byte of a read: caller withholds the ack
                        txv <= {8'hff, ~cmd_ack_in};
                        state <= M_BITS;
                     end
                     default: begin
                        txv <= 9'h1ff;
                        then_stop <= 1'b1;
                        state <= M_BITS;
                     end
                  endcase
               end
            end
            M_START: begin
               if (tick) begin
                  case (ph)
                     2'h0: sda_low <= 1'b0;
                     2'h1: scl_low <= 1'b0;
                     2'h2: sda_low <= 1'b1;
                     default: begin
                        scl_low <= 1'b1;
                        state <= M_IDLE;
                        cmd_ready_out <= 1'b1;
                        done_out <= 1'b1;
                     end
                  endcase
               end
            end
            M_BITS: begin
               if (tick) begin
                  case (ph)
                     2'h0: sda_low <= ~txv[8];
                     2'h1: scl_low <= 1'b0;
                     2'h2: rxv <= {rxv[7:0], sda_s};
                     default: begin
                        scl_low <= 1'b1;
                        txv <= {txv[7:0], 1'b1};
                        nbit <= nbit + 4'h1;
                        if (nbit == RECOVER_LAST) begin
                           if (then_stop) begin
                              state <= M_STOP;
                           end else begin
                              state <= M_IDLE;
                              cmd_ready_out <= 1'b1;
                              done_out <= 1'b1;
                              rd_data_out <= rxv[8:1];
                              ack_out <= ~rxv[0];
                           end
                        end
                     end
                  endcase
               end
            end
            M_STOP: begin
               if (tick) begin
                  case (ph)
                     2'h0: sda_low <= 1'b1;
                     2'h1: scl_low <= 1'b0;
                     2'h2: sda_low <= 1'b0;
                     default: begin
                        state <= M_IDLE;
                        cmd_ready_out <= 1'b1;
                        done_out <= 1'b1;
                     end
                  endcase
               end
            end
            default: state <= M_IDLE;
         endcase
      end
   end

   // ==========================================
   // open-drain drivers
   assign link.scl_m_oe = scl_low;
   assign link.scl_m_out = 1'b0;
   assign link.sda_m_oe = sda_low;
   assign link.sda_m_out = 1'b0;
endmodule
`default_nettype wire

/* verif/i2c_link_properties.sv */
// checker for the two-wire link, watched from the slave's clock
// assumes raw resolved lines and the slave's drive enable as inputs
`timescale 1ns/1ps
`default_nettype none
module i2c_link_properties
   import rtc_i2c_pkg::*;
(
   // link clock domain
   input wire logic link_clk_in,
   input wire logic rst_in,
   // link lines
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_d_oe
);
   // ==========================================
   // bus event tracking
   logic scl_q, sda_q, got, data_phase, nacked;
   logic [3:0] cnt;
   logic [7:0] sh;
   logic [7:0] addr_byte;
   logic rise, fall, start, own, wr_own;
   assign rise = ~scl_q & scl;
   assign fall = scl_q & ~scl;
   assign start = scl_q & scl & sda_q & ~sda;
   assign own = addr_byte[7:1] == SLAVE_ADDR;
   assign wr_own = got & own & ~addr_byte[0];

   always_ff @(posedge link_clk_in) begin
      scl_q <= rst_in | scl;
      sda_q <= rst_in | sda;
   end

   // rises counted, not falls: the fall closing a start is no bit
   always_ff @(posedge link_clk_in) begin
      if (rst_in || start) begin
         cnt <= 4'h0;
      end else if (rise) begin
         cnt <= (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
      end
   end

   always_ff @(posedge link_clk_in) begin
      if (rise) begin
         sh <= {sh[6:0], sda};
      end
      if (rst_in || start) begin
         got <= 1'b0;
         data_phase <= 1'b0;
         nacked <= 1'b0;
         addr_byte <= 8'h00;
      end else if (rise) begin
         if (cnt == 4'h7 && !data_phase) begin
            addr_byte <= {sh[6:0], sda};
            got <= 1'b1;
         end
         if (cnt == 4'h9 && got) begin
            data_phase <= 1'b1;
         end
         if (cnt == 4'h8 && data_phase && addr_byte[0] && sda) begin
            nacked <= 1'b1;
         end
      end
   end

   // ==========================================
   // properties
   property p_ack_own;
      @(posedge link_clk_in) disable iff (rst_in) rise && cnt == 4'h8 && got && own && !data_phase |-> sda_d_oe;
   endproperty
   a_ack_own: assert property (p_ack_own) else $error("own address not acknowledged");

   property p_foreign_quiet;
      @(posedge link_clk_in) disable iff (rst_in) got && !own && scl |-> !sda_d_oe;
   endproperty
   a_foreign_quiet: assert property (p_foreign_quiet) else $error("slave drove data for foreign address");

   property p_ack_write;
      @(posedge link_clk_in) disable iff (rst_in) rise && cnt == 4'h8 && wr_own && data_phase |-> sda_d_oe;
   endproperty
   a_ack_write: assert property (p_ack_write) else $error("written byte not acknowledged");

   property p_write_free;
      // ack is already driven at the ninth rise itself, before cnt reads nine
      @(posedge link_clk_in) disable iff (rst_in) wr_own && scl && scl_q && cnt != 4'h9 |-> !sda_d_oe;
   endproperty
   a_write_free: assert property (p_write_free) else $error("slave drove data bit of a write");

   property p_nack_release;
      @(posedge link_clk_in) disable iff (rst_in) nacked && scl |-> !sda_d_oe;
   endproperty
   a_nack_release: assert property (p_nack_release) else $error("data line held after missing acknowledge");

   property p_oe_steady;
      @(posedge link_clk_in) disable iff (rst_in) scl && $past(scl) |-> $stable(sda_d_oe);
   endproperty
   a_oe_steady: assert property (p_oe_steady) else $error("slave drive changed while clock high");

   property p_ack_prompt;
      @(posedge link_clk_in) disable iff (rst_in) fall && cnt == 4'h8 && wr_own |-> ##[1:12] sda_d_oe;
   endproperty
   a_ack_prompt: assert property (p_ack_prompt) else $error("acknowledge not driven after eighth bit");

   property p_ack_end;
      @(posedge link_clk_in) disable iff (rst_in) fall && cnt == 4'h9 && wr_own |-> ##[1:12] !sda_d_oe;
   endproperty
   a_ack_end: assert property (p_ack_end) else $error("acknowledge held past ninth bit");
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// self-checking bench: master and rtc slave joined over the link
// inputs change at mclk falling edge; link clock has its own phase
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import rtc_i2c_pkg::*;
;
   logic mclk_in = 1'b0;
   logic link_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic link_rst = 1'b1;
   logic cmd_valid_in = 1'b0;
   mst_cmd_t cmd_kind_in = CMD_STOP;
   logic [7:0] cmd_data_in = 8'h00;
   logic cmd_ack_in = 1'b0;
   logic cmd_ready_out, done_out, ack_out, wr_valid_out, rd_take_out, busy_out, sel_out;
   logic [7:0] rd_data_out, wr_data_out, rd_data_in;
   logic [PTR_W-1:0] wr_addr_out, rd_addr_out;
   logic [7:0] regs [32] = '{default: 8'h00};
   logic [7:0] exp_regs [32] = '{default: 8'h00};
   logic [12:0] wr_q [$];
   logic [6:0] bad [4] = '{7'h50, 7'h53, 7'h11, 7'h71};
   logic [31:0] seed = 32'h1c;
   int err_total = 0;
   int samples_checked = 0;
   int cycles = 0;
   int take_cnt = 0;

   // ==========================================
   // clocks, design and checker
   always #25 mclk_in = ~mclk_in;
   always begin
      if ($time == 0) #1.1;
      #7.5 link_clk_in = ~link_clk_in;
   end
   // slave side reset, retimed onto the link clock
   always @(negedge link_clk_in) link_rst <= rst_in;

   i2c_link_if link();
   i2c_rtc_master u_i2c_rtc_master (.mclk_in(mclk_in), .rst_in(rst_in), .link(link),
      .cmd_valid_in(cmd_valid_in), .cmd_kind_in(cmd_kind_in), .cmd_data_in(cmd_data_in),
      .cmd_ack_in(cmd_ack_in), .cmd_ready_out(cmd_ready_out), .done_out(done_out),
      .rd_data_out(rd_data_out), .ack_out(ack_out));
   i2c_rtc_slave u_i2c_rtc_slave (.link_clk_in(link_clk_in), .rst_in(link_rst), .link(link),
      .wr_valid_out(wr_valid_out), .wr_addr_out(wr_addr_out), .wr_data_out(wr_data_out),
      .rd_addr_out(rd_addr_out), .rd_data_in(rd_data_in), .rd_take_out(rd_take_out),
      .busy_out(busy_out), .sel_out(sel_out));
   i2c_link_properties u_i2c_link_properties (.link_clk_in(link_clk_in), .rst_in(link_rst),
      .scl(link.scl), .sda(link.sda), .sda_d_oe(link.sda_d_oe));

   assign rd_data_in = regs[rd_addr_out];

   // ==========================================
   // helpers
   function automatic logic [31:0] nxt(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction

   function automatic logic [4:0] ptr_at(input logic [4:0] p, input int i);
      return p + 5'(i);
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] expv);
      samples_checked++;
      if (seen !== expv) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, expv);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // hang is caught by the cycle ceiling, not here
   task automatic cmd(input mst_cmd_t k, input logic [7:0] d, input logic a);
      cmd_valid_in = 1'b1;
      cmd_kind_in = k;
      cmd_data_in = d;
      cmd_ack_in = a;
      @(negedge mclk_in);
      cmd_valid_in = 1'b0;
      check({15'h0, cmd_ready_out}, 16'h0);
      while (done_out !== 1'b1) @(negedge mclk_in);
      check({15'h0, cmd_ready_out}, 16'h1);
   endtask

   task automatic wbyte(input logic [7:0] d, input logic a);
      cmd(CMD_WRITE, d, 1'b0);
      check({15'h0, ack_out}, {15'h0, a});
   endtask

   // write n random bytes from p, then read them back after a restart
   task automatic xfer(input logic [4:0] p, input int n);
      logic [7:0] d;
      int t0;
      seed = nxt(seed);
      t0 = take_cnt;
      cmd(CMD_START, 8'h00, 1'b0);
      wbyte({SLAVE_ADDR, 1'b0}, 1'b1);
      check({15'h0, sel_out}, 16'h1);
      wbyte({seed[7:5], p}, 1'b1);
      for (int i = 0; i < n; i++) begin
         seed = nxt(seed);
         d = seed[15:8];
         exp_regs[ptr_at(p, i)] = d;
         wr_q.push_back({ptr_at(p, i), d});
         wbyte(d, 1'b1);
      end
      cmd(CMD_STOP, 8'h00, 1'b0);
      cmd(CMD_START, 8'h00, 1'b0);
      wbyte({SLAVE_ADDR, 1'b0}, 1'b1);
      wbyte({seed[23:21], p}, 1'b1);
      cmd(CMD_START, 8'h00, 1'b0);
      wbyte({SLAVE_ADDR, 1'b1}, 1'b1);
      for (int i = 0; i < n; i++) begin
         cmd(CMD_READ, 8'h00, i != n - 1);
         check({8'h0, rd_data_out}, {8'h0, exp_regs[ptr_at(p, i)]});
      end
      // slave must already be idle after the missing ack, before any stop
      repeat (4) @(negedge mclk_in);
      check({15'h0, busy_out}, 16'h0);
      cmd(CMD_STOP, 8'h00, 1'b0);
      check({15'h0, busy_out}, 16'h0);
      check(16'(take_cnt - t0), 16'(n));
   endtask

   // ==========================================
   // register array behind the slave
   always @(posedge link_clk_in) begin
      if (rd_take_out === 1'b1) begin
         take_cnt++;
      end
      if (wr_valid_out === 1'b1) begin
         regs[wr_addr_out] <= wr_data_out;
         check({3'h0, wr_addr_out, wr_data_out}, (wr_q.size() > 0) ? {3'h0, wr_q.pop_front()} : 16'hffff);
      end
   end

   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 60000) begin
         err_total++;
         tally_and_finish();
      end
   end

   // ==========================================
   // main sequence
   initial begin
      repeat (8) @(negedge mclk_in);
      rst_in = 1'b0;
      repeat (4) @(negedge mclk_in);
      xfer(5'h1e, 4);
      for (int k = 0; k < 3; k++) begin
         seed = nxt(seed);
         xfer(seed[4:0], 1 + int'(seed[9:8]));
      end
      for (int j = 0; j < 4; j++) begin
         cmd(CMD_START, 8'h00, 1'b0);
         wbyte({bad[j], 1'(j)}, 1'b0);
         check({15'h0, sel_out}, 16'h0);
         cmd(CMD_STOP, 8'h00, 1'b0);
      end
      // stall the bus in mid-read, then recover
      cmd(CMD_START, 8'h00, 1'b0);
      wbyte({SLAVE_ADDR, 1'b1}, 1'b1);
      cmd(CMD_READ, 8'h00, 1'b1);
      cmd(CMD_RECOVER, 8'h00, 1'b0);
      check({15'h0, busy_out}, 16'h0);
      xfer(5'h00, 1);
      tally_and_finish();
   end
endmodule
`default_nettype wire
